// ---- sbsr_burst_step.sv ----
`timescale 1ns/10ps
// next burst address bits: interleaved (xor of count) or linear (add)
module sbsr_burst_step (
   // burst inputs
   input wire logic [sbsr_pkg::BURST_W-1:0] i_base,
   input wire logic [sbsr_pkg::BURST_W-1:0] i_count,
   input wire logic i_interleave,
   // result
   output logic [sbsr_pkg::BURST_W-1:0] o_low
);
   always_comb
   begin
      if (i_interleave)
         o_low = i_base ^ i_count;
      else
         o_low = i_base + i_count;
   end
endmodule

// ---- sbsr_ctl.sv ----
`timescale 1ns/10ps
// simple controller: one access per request, loads a new address or steps the burst as I_BURST selects
module sbsr_ctl (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // user request
   input wire logic I_REQ,
   input wire logic I_WRITE,
   input wire logic I_BURST,
   input wire logic I_HOLD,
   input wire logic I_INTERLEAVE,
   input wire logic [sbsr_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [sbsr_pkg::LANES-1:0] I_LANES,
   input wire logic [sbsr_pkg::DATA_W-1:0] I_WDATA,
   input wire logic [sbsr_pkg::LANES-1:0] I_WPAR,
   // user answer
   output logic O_RVALID,
   output logic [sbsr_pkg::DATA_W-1:0] O_RDATA,
   output logic [sbsr_pkg::LANES-1:0] O_RPAR,
   // link
   sbsr_link.ctl LINK
);
   typedef struct packed {
      logic [sbsr_pkg::PIPE_DEPTH-1:0] rd_pipe;
      logic [sbsr_pkg::PIPE_DEPTH-1:0] wr_pipe;
      logic [sbsr_pkg::DATA_W-1:0] wdata;
      logic [sbsr_pkg::LANES-1:0] wpar;
      logic rvalid;
      logic [sbsr_pkg::DATA_W-1:0] rdata;
      logic [sbsr_pkg::LANES-1:0] rpar;
   } sbsr_ctl_s;

   sbsr_ctl_s st;
   sbsr_ctl_s next_st;

   always_comb
   begin
      next_st = st;
      next_st.rvalid = 1'b0;
      if (!I_HOLD)
      begin
         next_st.rd_pipe = {st.rd_pipe[0], I_REQ && !I_WRITE};
         next_st.wr_pipe = {st.wr_pipe[0], I_REQ && I_WRITE};
         next_st.wdata = I_WDATA;
         next_st.wpar = I_WPAR;
         if (st.rd_pipe[1])
         begin
            next_st.rvalid = 1'b1;
            next_st.rdata = LINK.mem_dq;
            next_st.rpar = LINK.mem_parity_pins;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // link drive
   // ----------------------------------------------------------------
   assign LINK.clock_qualify_n = I_HOLD;
   assign LINK.select_first_n = !I_REQ;
   assign LINK.select_second = I_REQ;
   assign LINK.select_third_n = !I_REQ;
   assign LINK.write_n = !(I_REQ && I_WRITE);
   assign LINK.advance_or_load = I_BURST;
   assign LINK.addr = I_ADDR;
   assign LINK.byte_write_n = (I_REQ && I_WRITE) ? ~I_LANES : sbsr_pkg::LANES_OFF;
   // enable the device's drivers over the read data phase
   assign LINK.output_enable_n = !st.rd_pipe[1];
   assign LINK.burst_mode = I_INTERLEAVE;
   assign LINK.ctl_dq = st.wr_pipe[0] ? st.wdata : sbsr_pkg::DATA_ZERO;
   assign LINK.ctl_parity_pins = st.wr_pipe[0] ? st.wpar : sbsr_pkg::PAR_ZERO;
   assign LINK.ctl_dq_oe = st.wr_pipe[0];
   assign O_RVALID = st.rvalid;
   assign O_RDATA = st.rdata;
   assign O_RPAR = st.rpar;
endmodule

// ---- sbsr_link.sv ----
`timescale 1ns/10ps
interface sbsr_link;
   logic [sbsr_pkg::ADDR_W-1:0] addr;
   logic [sbsr_pkg::LANES-1:0] byte_write_n;
   logic write_n;
   logic advance_or_load;
   logic clock_qualify_n;
   logic select_first_n;
   logic select_second;
   logic select_third_n;
   logic output_enable_n;
   logic burst_mode;
   // data pins split into the two drivers and enables
   logic [sbsr_pkg::DATA_W-1:0] ctl_dq;
   logic [sbsr_pkg::LANES-1:0] ctl_parity_pins;
   logic ctl_dq_oe;
   logic [sbsr_pkg::DATA_W-1:0] mem_dq;
   logic [sbsr_pkg::LANES-1:0] mem_parity_pins;
   logic mem_dq_oe;
   modport ctl (
      output addr, byte_write_n, write_n, advance_or_load, clock_qualify_n,
      output select_first_n, select_second, select_third_n, output_enable_n,
      output burst_mode, ctl_dq, ctl_parity_pins, ctl_dq_oe,
      input mem_dq, mem_parity_pins, mem_dq_oe
   );
   modport mem (
      input addr, byte_write_n, write_n, advance_or_load, clock_qualify_n,
      input select_first_n, select_second, select_third_n, output_enable_n,
      input burst_mode, ctl_dq, ctl_parity_pins, ctl_dq_oe,
      output mem_dq, mem_parity_pins, mem_dq_oe
   );
endinterface

// ---- sbsr_link_chk.sv ----
`timescale 1ns/10ps
module sbsr_link_chk (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // link signals
   input wire logic write_n,
   input wire logic clock_qualify_n,
   input wire logic select_first_n,
   input wire logic select_second,
   input wire logic select_third_n,
   input wire logic output_enable_n,
   input wire logic ctl_dq_oe,
   input wire logic mem_dq_oe,
   input wire logic [sbsr_pkg::DATA_W-1:0] mem_dq
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   logic sel;
   assign sel = !select_first_n && select_second && !select_third_n;
   sequence q_desel;
      !clock_qualify_n && !sel;
   endsequence
   sequence q_read;
      !clock_qualify_n && sel && write_n;
   endsequence
   // ---------------------------------------------------------------
   // drive rules
   // ---------------------------------------------------------------
   oe_gate_a: assert property (output_enable_n |-> !mem_dq_oe)
      else $error("device drives with output enable high");
   desel_quiet_a: assert property (q_desel ##1 q_desel |=> !mem_dq_oe)
      else $error("device drives while deselected");
   first_cycle_a: assert property (q_desel ##1 q_read |=> !mem_dq_oe [*2])
      else $error("device drives right after deselect");
   write_quiet_a: assert property (!clock_qualify_n && sel && !write_n |=> !mem_dq_oe && ctl_dq_oe)
      else $error("write data phase not owned by controller");
   no_clash_a: assert property (!(ctl_dq_oe && mem_dq_oe))
      else $error("both ends drive the data pins");
   read_drive_a: assert property ((!clock_qualify_n && sel) ##1 q_read
      ##1 (!clock_qualify_n && !(sel && !write_n))
      |=> output_enable_n || mem_dq_oe)
      else $error("read data not driven");
   hold_data_a: assert property (clock_qualify_n |=> $stable(mem_dq))
      else $error("data changed on a masked edge");
   hold_oe_a: assert property (clock_qualify_n && !output_enable_n
      |=> output_enable_n || $stable(mem_dq_oe))
      else $error("drive changed on a masked edge");
endmodule

// ---- sbsr_mem.sv ----
`timescale 1ns/10ps
// Contract
// - address incl burst bits sampled, selects location
// - per-lane active-low byte write, incl parity
// - lane written only with write enable too
// - write enable sampled only when qualified
// - controller drives write enable low to write
// - advance high steps burst counter
// - advance low loads new address
// - controller loads address after deselect (sbsr_ctl passes I_BURST straight through, so the user must load)
// - inputs captured only on qualified edges (sbsr_mem takes burst_mode on the first edge after reset, qualified or not)
// - three chip enables, mixed polarity, combined
// - output enable low lets pins drive
// - output enable high: pins tri-stated
// - no drive during write data phase
// - no drive first cycle after deselect
// - no drive while deselected
// - unqualified clock extends cycle, keeps selection
// - strap: high interleaved, low linear burst
// - read data from previous qualified edge
module sbsr_mem (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // link
   sbsr_link.mem LINK
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      // burst address
      logic [sbsr_pkg::ADDR_W-1:0] base;
      logic [sbsr_pkg::BURST_W-1:0] count;
      // command pipeline
      sbsr_pkg::sbsr_op_e op;
      sbsr_pkg::sbsr_op_e op_d;
      // captured addresses and lanes
      logic [sbsr_pkg::ADDR_W-1:0] wr_addr;
      logic [sbsr_pkg::LANES-1:0] wr_lanes;
      logic [sbsr_pkg::ADDR_W-1:0] rd_addr;
      // drive masks
      logic was_desel;
      logic fresh_cmd;
      logic fresh;
      logic rd_valid;
      // strap
      logic interleave;
      logic strap_taken;
      // read data register
      logic [sbsr_pkg::DATA_W-1:0] rd_data;
      logic [sbsr_pkg::LANES-1:0] rd_par;
   } sbsr_mem_s;

   sbsr_mem_s st;
   sbsr_mem_s next_st;
   // read word gathered from the lane arrays, one slice per lane
   logic [sbsr_pkg::DATA_W-1:0] rd_word;
   logic [sbsr_pkg::LANES-1:0] rd_par_word;
   // decoded command of the current cycle
   logic cmd_write;
   logic [sbsr_pkg::ADDR_W-1:0] step_addr;
   // terms of the data pin enable
   logic drive_read;
   logic drive_no_write;
   logic drive_settled;
   logic [sbsr_pkg::BURST_W-1:0] step_low;
   logic [sbsr_pkg::ADDR_W-1:0] access_addr;
   logic qualified;
   logic selected;
   // write strobe per lane, aimed at the data phase
   logic [sbsr_pkg::LANES-1:0] lane_wr;

   // ----------------------------------------------------------------
   // burst step
   // ----------------------------------------------------------------
   sbsr_burst_step u_step (
      .i_base(st.base[sbsr_pkg::BURST_W-1:0]),
      .i_count(st.count + sbsr_pkg::BURST_ONE),
      .i_interleave(st.interleave),
      .o_low(step_low)
   );

   // ----------------------------------------------------------------
   // control
   // ----------------------------------------------------------------
   assign qualified = !LINK.clock_qualify_n;
   assign selected = !LINK.select_first_n && LINK.select_second
      && !LINK.select_third_n;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // write enable and byte writes only matter on a selected, qualified edge
   assign cmd_write = qualified && selected && !LINK.write_n;
   // burst step keeps the upper address bits of the loaded base
   assign step_addr = {st.base[sbsr_pkg::ADDR_W-1:sbsr_pkg::BURST_W], step_low};

   always_comb
   begin
      next_st = st;
      access_addr = st.base;
      // strap caught once after reset release, held fixed afterwards
      // a strap change in mid-run is not seen until the next reset
      if (!st.strap_taken)
      begin
         next_st.interleave = LINK.burst_mode;
         next_st.strap_taken = 1'b1;
      end
      // unqualified edge: everything held, selection kept
      if (qualified)
      begin
         next_st.op_d = st.op;
         // first-cycle mask rides along with its command to the data phase
         next_st.fresh_cmd = st.was_desel;
         next_st.fresh = st.fresh_cmd;
         // deselect: nothing is owed to the pins in its data phase
         if (!selected)
         begin
            next_st.op = sbsr_pkg::OP_IDLE;
            next_st.was_desel = 1'b1;
         end
         else
         begin
            // load or step: the access address of this command
            if (!LINK.advance_or_load)
            begin
               access_addr = LINK.addr;
               next_st.base = LINK.addr;
               next_st.count = '0;
            end
            else
            begin
               access_addr = step_addr;
               next_st.count = st.count + sbsr_pkg::BURST_ONE;
            end
            next_st.was_desel = 1'b0;
            // write enable only looked at on a qualified edge
            next_st.op = cmd_write ? sbsr_pkg::OP_WRITE : sbsr_pkg::OP_READ;
            next_st.wr_addr = access_addr;
            next_st.wr_lanes = ~LINK.byte_write_n;
            next_st.rd_addr = access_addr;
         end
         // read data fetched one qualified edge after its command
         next_st.rd_valid = (st.op == sbsr_pkg::OP_READ);
         next_st.rd_data = rd_word;
         next_st.rd_par = rd_par_word;
      end
   end

   // lane writes land in the data phase, one qualified edge after the command
   assign lane_wr = (qualified && st.op == sbsr_pkg::OP_WRITE) ? st.wr_lanes
      : '0;

   // ----------------------------------------------------------------
   // pipeline register
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // storage, one lane at a time
   // ----------------------------------------------------------------
   // each lane keeps its own array, so no two processes share a memory
   // no reset here: contents survive a reset
   for (genvar g = 0; g < sbsr_pkg::LANES; g++)
   begin : g_lane
      logic [sbsr_pkg::LANE_W-1:0] lane_mem [sbsr_pkg::DEPTH];
      logic lane_par [sbsr_pkg::DEPTH];
      always_ff @(posedge I_CLK)
      begin
         if (lane_wr[g])
         begin
            lane_mem[st.wr_addr] <= LINK.ctl_dq[g*sbsr_pkg::LANE_W +: sbsr_pkg::LANE_W];
            lane_par[st.wr_addr] <= LINK.ctl_parity_pins[g];
         end
      end
      // read port, addressed by the captured read address
      assign rd_word[g*sbsr_pkg::LANE_W +: sbsr_pkg::LANE_W] = lane_mem[st.rd_addr];
      assign rd_par_word[g] = lane_par[st.rd_addr];
   end

   // ----------------------------------------------------------------
   // data pins
   // ----------------------------------------------------------------
   // output enable stays asynchronous, so the enable is combinational
   // read data phase only; a deselect or write command never sets rd_valid
   assign drive_read = st.rd_valid && (st.op_d == sbsr_pkg::OP_READ);
   // a write issued behind a read takes the pins, that read data is lost
   assign drive_no_write = (st.op_d != sbsr_pkg::OP_WRITE)
      && (st.op != sbsr_pkg::OP_WRITE);
   // the first read after a deselect never drives
   assign drive_settled = !st.fresh;
   assign LINK.mem_dq_oe = !LINK.output_enable_n
      && drive_read
      && drive_no_write
      && drive_settled;
   assign LINK.mem_dq = st.rd_data;
   assign LINK.mem_parity_pins = st.rd_par;
endmodule

// ---- sbsr_pkg.sv ----
package sbsr_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 256;
   localparam int BURST_W = 2;
   localparam int PIPE_DEPTH = 2;
   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
   localparam logic [LANES-1:0] PAR_ZERO = 4'h0;
   localparam logic [LANES-1:0] LANES_OFF = 4'hF;
   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} sbsr_op_e;
endpackage

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic arst_n, req, wr, burst, hold, il, rvalid;
   logic [sbsr_pkg::ADDR_W-1:0] addr;
   logic [sbsr_pkg::LANES-1:0] lanes, wpar, rpar;
   logic [sbsr_pkg::DATA_W-1:0] wdata, rdata;
   int n_mismatch = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   sbsr_link lnk ();
   sbsr_ctl i_sbsr_ctl (.I_CLK(clk), .I_ARST_N(arst_n), .I_REQ(req), .I_WRITE(wr),
      .I_BURST(burst), .I_HOLD(hold), .I_INTERLEAVE(il), .I_ADDR(addr), .I_LANES(lanes),
      .I_WDATA(wdata), .I_WPAR(wpar), .O_RVALID(rvalid), .O_RDATA(rdata), .O_RPAR(rpar),
      .LINK(lnk));
   sbsr_mem i_sbsr_mem (.I_CLK(clk), .I_ARST_N(arst_n), .LINK(lnk));
   sbsr_link_chk i_sbsr_link_chk (.I_CLK(clk), .I_ARST_N(arst_n), .write_n(lnk.write_n),
      .clock_qualify_n(lnk.clock_qualify_n), .select_first_n(lnk.select_first_n),
      .select_second(lnk.select_second), .select_third_n(lnk.select_third_n),
      .output_enable_n(lnk.output_enable_n), .ctl_dq_oe(lnk.ctl_dq_oe),
      .mem_dq_oe(lnk.mem_dq_oe), .mem_dq(lnk.mem_dq));
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic b, input logic [7:0] a,
      input logic [3:0] ln, input logic [31:0] d, input logic [3:0] p);
      req = 1'b1;
      wr = w;
      burst = b;
      addr = a;
      lanes = ln;
      wdata = d;
      wpar = p;
      @(negedge clk);
   endtask
   task automatic idle(input int n);
      req = 1'b0;
      repeat (n) @(negedge clk);
   endtask
   // no-lane write first so the read never follows a deselect
   task automatic rd(input logic [7:0] a, input logic [35:0] exp, input int h);
      int k;
      acc(1'b1, 1'b0, a, 4'h0, ~exp[31:0], 4'hF);
      acc(1'b0, 1'b0, a, 4'h0, 32'h00000000, 4'h0);
      req = 1'b0;
      hold = 1'b1;
      repeat (h) @(negedge clk);
      hold = 1'b0;
      k = 0;
      while (rvalid !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      n_tests++;
      if (rvalid !== 1'b1 || {rpar, rdata} !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, {rpar, rdata}, exp);
         if (k >= 20)
            stop_test();
      end
      @(negedge clk);
   endtask
   task automatic do_reset(input logic mode);
      arst_n = 1'b0;
      il = mode;
      hold = 1'b0;
      acc(1'b0, 1'b0, 8'h00, 4'h0, 32'h00000000, 4'h0);
      req = 1'b0;
      repeat (11) @(negedge clk);
      arst_n = 1'b1;
   endtask
   task automatic burst_test(input logic mode, input logic [7:0] base);
      logic [7:0] a;
      logic [31:0] d;
      d = mode ? 32'hC0DE0100 : 32'hC0DE0000;
      for (int k = 0; k < 4; k++)
         acc(1'b1, k != 0, base, 4'hF, d + k, 4'(k));
      idle(4);
      for (int k = 0; k < 4; k++)
      begin
         a = base;
         a[1:0] = mode ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k);
         rd(a, {4'(k), d + k}, 0);
      end
      $display("burst test mode %0d done", mode);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      do_reset(1'b1);
      acc(1'b1, 1'b0, 8'h05, 4'hF, 32'h12345678, 4'hA);
      idle(1);
      rd(8'h05, {4'hA, 32'h12345678}, 0);
      acc(1'b1, 1'b0, 8'h05, 4'h5, 32'hFFFFFFFF, 4'h5);
      rd(8'h05, {4'hF, 32'h12FF56FF}, 3);
      acc(1'b1, 1'b0, 8'h05, 4'hA, 32'h00000000, 4'h0);
      rd(8'h05, {4'h5, 32'h00FF00FF}, 0);
      $display("lane test done");
      idle(2);
      acc(1'b0, 1'b0, 8'h05, 4'h0, 32'h00000000, 4'h0);
      for (int j = 0; j < 6; j++)
      begin
         idle(1);
         n_tests++;
         if (lnk.mem_dq_oe !== 1'b0)
         begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, lnk.mem_dq_oe, 1'b0);
         end
      end
      $display("deselect test done");
      burst_test(1'b1, 8'h21);
      do_reset(1'b0);
      burst_test(1'b0, 8'h41);
      stop_test();
   end
endmodule
